// >>> hpl_field_model.sv
`timescale 1ns/1ps
// encoder index source: pulses only while the axis is moving
module hpl_field_model (
  // clock and motion
  input wire logic sys_clk_i,
  input wire logic move_en_i,
  // index gate and delay
  input wire logic idx_on_i,
  input wire logic [7:0] dly_i,
  // index pin
  output logic enc_index_o = 1'b0
);
  // cycles moved since motion began
  logic [7:0] cnt = 8'h00;
  // 4-cycle pulse after dly_i, so the 2ff sync never misses it
  always_ff @(posedge sys_clk_i) begin
    cnt <= move_en_i ? cnt + 8'h01 : 8'h00;
    enc_index_o <= idx_on_i && move_en_i && cnt >= dly_i && cnt < dly_i + 8'h04;
  end
endmodule : hpl_field_model

// >>> hpl_homing_probe.sv
`timescale 1ns/1ps
// Behaviour
// - selectors 15, 16, 31, 32 never start homing
// - signed selector, -3..35, resets 1, writable anytime
// - method -3 forward, first index is home
// - -2 forward, positive end stop, then index
// - -1 reverse, negative end stop, then index
// - 1 reverse, index after negative limit falls
// - 2 forward, index after positive limit falls
// - 3..8, 11, 12 home switch same side
// - 9, 10 forward, far side edge then index
// - 13, 14 reverse, far side edge then index
// - 17..30 mirror 1..14, edge is home
// - 33 reverse, first index is home
// - 34 forward, first index is home
// - 35 current position is home, no motion
// - switch search speed, reset 13981013, stopped only
// - zero search speed, reset 1398101, stopped only
// - homing acceleration sampled at run start
// - zero acceleration forced to 1, special case quick stop max
// - probe1 rising edge latches position
// - probe1 falling edge latches position
// - probe2 rising edge latches position
// - homing done loads position with home offset
module hpl_homing_probe
  import hpl_pkg::*;
#(
  parameter logic [31:0] TIMEOUT_CYCLES = HOMING_TIMEOUT_CYCLES,
  parameter int ENC_BITS = 23
) (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // field pins, asynchronous
  input wire logic neg_limit_i,
  input wire logic pos_limit_i,
  input wire logic home_switch_i,
  input wire logic enc_index_i,
  input wire logic probe1_i,
  input wire logic probe2_i,
  // same-domain drive signals
  input wire logic neg_end_stop_i,
  input wire logic pos_end_stop_i,
  input wire logic [31:0] pos_feedback_i,
  // motion request to profile generator
  output logic move_en_o,
  output logic move_fwd_o,
  output logic [31:0] speed_o,
  output logic [31:0] accel_o,
  output logic [31:0] decel_o,
  // position load and status
  output logic pos_load_o,
  output logic [31:0] pos_load_val_o,
  output logic homing_busy_o,
  output logic homing_done_o,
  output logic homing_timeout_error_o
);

  // elaboration checks
  if (TIMEOUT_CYCLES == 32'h0) begin : g_bad_timeout
    $error("timeout count must be nonzero");
  end
  if (ENC_BITS < 1 || ENC_BITS > 32) begin : g_bad_enc
    $error("encoder width out of range");
  end

  // descriptor for base methods -3..14, zero when undefined
  function automatic logic [7:0] base_info(input logic signed [15:0] m);
    logic [7:0] r;
    r = 8'h00;
    case (m)
      -16'sd3: r = {1'b1, 1'b1, SRC_NONE, 1'b0, 1'b0, 1'b1};
      -16'sd2: r = {1'b1, 1'b1, SRC_POS_STOP, 1'b0, 1'b0, 1'b1};
      -16'sd1: r = {1'b1, 1'b0, SRC_NEG_STOP, 1'b0, 1'b0, 1'b1};
      16'sd1: r = {1'b1, 1'b0, SRC_NEG_LIM, 1'b1, 1'b0, 1'b1};
      16'sd2: r = {1'b1, 1'b1, SRC_POS_LIM, 1'b1, 1'b0, 1'b1};
      16'sd3, 16'sd7: r = {1'b1, 1'b1, SRC_HOME, 1'b1, 1'b0, 1'b1};
      16'sd4, 16'sd8: r = {1'b1, 1'b1, SRC_HOME, 1'b0, 1'b0, 1'b1};
      16'sd5, 16'sd11: r = {1'b1, 1'b0, SRC_HOME, 1'b1, 1'b0, 1'b1};
      16'sd6, 16'sd12: r = {1'b1, 1'b0, SRC_HOME, 1'b0, 1'b0, 1'b1};
      16'sd9: r = {1'b1, 1'b1, SRC_HOME, 1'b0, 1'b1, 1'b1};
      16'sd10: r = {1'b1, 1'b1, SRC_HOME, 1'b1, 1'b1, 1'b1};
      16'sd13: r = {1'b1, 1'b0, SRC_HOME, 1'b0, 1'b1, 1'b1};
      16'sd14: r = {1'b1, 1'b0, SRC_HOME, 1'b1, 1'b1, 1'b1};
      default: r = 8'h00;
    endcase
    return r;
  endfunction : base_info

  // full descriptor; undefined selectors come back invalid
  function automatic logic [7:0] method_info(input logic signed [15:0] m);
    logic [7:0] r;
    r = 8'h00;
    if (m >= 16'sd17 && m <= 16'sd30) begin
      // mirror of m-16 with the edge itself as home
      r = base_info(16'(m - 16'sd16));
      r[MI_INDEX] = 1'b0;
    end else if (m == 16'sd33) begin
      r = {1'b1, 1'b0, SRC_NONE, 1'b0, 1'b0, 1'b1};
    end else if (m == 16'sd34) begin
      r = {1'b1, 1'b1, SRC_NONE, 1'b0, 1'b0, 1'b1};
    end else if (m == 16'sd35) begin
      r = {1'b1, 1'b0, SRC_NONE, 1'b0, 1'b0, 1'b0};
    end else if (m <= 16'sd14) begin
      r = base_info(m);
    end else begin
      // 15, 16, 31, 32 stay invalid
      r = 8'h00;
    end
    return r;
  endfunction : method_info

  // register file
  logic [15:0] method_sel; // signed selector
  logic [31:0] homing_accel;
  logic [31:0] sw_speed;
  logic [31:0] zero_speed;
  logic [15:0] probe_ctrl;
  logic [15:0] probe_stat;
  logic [31:0] p1_rise_pos;
  logic [31:0] p1_fall_pos;
  logic [31:0] p2_rise_pos;
  logic [31:0] home_offset;
  logic [15:0] qs_option;
  logic [31:0] gear_ratio;

  // sequencer state
  hpl_state_t state;
  logic [7:0] run_info; // descriptor latched at start
  logic [31:0] timeout_cnt;
  logic done_flag;
  logic timeout_flag;
  logic undef_flag;
  logic qstop_flag;

  // pin synchronisers and edge history
  logic [PIN_COUNT-1:0] pin_meta;
  logic [PIN_COUNT-1:0] pin_sync;
  logic [PIN_COUNT-1:0] pin_prev;
  logic [PIN_COUNT-1:0] pin_rise;
  logic [PIN_COUNT-1:0] pin_fall;

  // apb decode
  logic apb_access;
  logic apb_commit;
  logic apb_wr;
  logic [13:0] reg_idx;
  logic addr_ok;
  logic [31:0] rd_data;
  logic rd_hit;
  logic start_req;
  logic qstop_req;

  // start and rule inputs of the sequencer
  logic [7:0] sel_info;
  logic [2:0] run_src;
  logic src_level;
  logic src_rise;
  logic src_fall;
  logic want_edge;
  logic special_case;

  // two sync flops and one history flop per pin; the first is never looked at
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else if (ce_i) begin
      pin_meta <= {probe2_i, probe1_i, enc_index_i, home_switch_i, pos_limit_i, neg_limit_i};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // edges from synchronised levels only
  assign pin_rise = pin_sync & ~pin_prev;
  assign pin_fall = ~pin_sync & pin_prev;

  // apb strobes; one wait state so read data comes from a flop
  assign apb_access = psel_i & penable_i;
  assign apb_commit = apb_access & pready_o;
  assign apb_wr = apb_commit & pwrite_i & ~pslverr_o;
  assign reg_idx = paddr_i[15:2];
  assign addr_ok = (paddr_i[1:0] == 2'b00) & rd_hit;
  assign start_req = apb_wr & (reg_idx == IDX_CTRL) & pwdata_i[CTRL_START_BIT];
  assign qstop_req = apb_wr & (reg_idx == IDX_CTRL) & pwdata_i[CTRL_QSTOP_BIT];

  // read mux; narrow registers zero-extend
  always_comb begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    case (reg_idx)
      IDX_METHOD: rd_data = {16'h0000, method_sel};
      IDX_ACCEL: rd_data = homing_accel;
      IDX_PROBE_CTRL: rd_data = {16'h0000, probe_ctrl};
      IDX_PROBE_STAT: rd_data = {16'h0000, probe_stat};
      IDX_P1_RISE: rd_data = p1_rise_pos;
      IDX_P1_FALL: rd_data = p1_fall_pos;
      IDX_P2_RISE: rd_data = p2_rise_pos;
      IDX_SW_SPEED: rd_data = sw_speed;
      IDX_ZERO_SPEED: rd_data = zero_speed;
      IDX_HOME_OFFSET: rd_data = home_offset;
      IDX_CTRL: rd_data = 32'h00000000; // command bits self-clear
      IDX_STATUS: rd_data = {27'h0000000, qstop_flag, undef_flag, timeout_flag,
                             done_flag, (state != ST_IDLE)};
      IDX_QS_OPTION: rd_data = {16'h0000, qs_option};
      IDX_GEAR: rd_data = gear_ratio;
      default: rd_hit = 1'b0;
    endcase
  end

  // apb answer: ready one cycle into the access phase
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else if (ce_i) begin
      if (apb_access && !pready_o) begin
        pready_o <= 1'b1;
        pslverr_o <= ~addr_ok;
        prdata_o <= (addr_ok && !pwrite_i) ? rd_data : 32'h00000000;
      end else begin
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
      end
    end
  end

  // writable registers; out-of-range selector writes are dropped
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      method_sel <= RST_METHOD;
      homing_accel <= RST_ACCEL;
      sw_speed <= RST_SW_SPEED;
      zero_speed <= RST_ZERO_SPEED;
      probe_ctrl <= RST_PROBE_CTRL;
      home_offset <= RST_HOME_OFFSET;
      qs_option <= RST_QS_OPTION;
      gear_ratio <= RST_GEAR;
    end else if (ce_i && apb_wr) begin
      case (reg_idx)
        IDX_METHOD: begin
          // accepted at any time, even mid-run
          if ($signed(pwdata_i[15:0]) >= METHOD_MIN && $signed(pwdata_i[15:0]) <= METHOD_MAX) begin
            method_sel <= pwdata_i[15:0];
          end
        end
        IDX_ACCEL: homing_accel <= pwdata_i;
        IDX_SW_SPEED: begin
          // a running search must not see its speed move
          if (state == ST_IDLE) begin
            sw_speed <= pwdata_i;
          end
        end
        IDX_ZERO_SPEED: begin
          if (state == ST_IDLE) begin
            zero_speed <= pwdata_i;
          end
        end
        IDX_PROBE_CTRL: probe_ctrl <= pwdata_i[15:0];
        IDX_HOME_OFFSET: home_offset <= pwdata_i;
        IDX_QS_OPTION: qs_option <= pwdata_i[15:0];
        IDX_GEAR: gear_ratio <= pwdata_i;
        default: begin
          // read-only and command registers store nothing
        end
      endcase
    end
  end

  // probe latches; capture on every qualifying edge
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      p1_rise_pos <= 32'h00000000;
      p1_fall_pos <= 32'h00000000;
      p2_rise_pos <= 32'h00000000;
    end else if (ce_i) begin
      if (pin_rise[PIN_PROBE1]) begin
        p1_rise_pos <= pos_feedback_i;
      end
      if (pin_fall[PIN_PROBE1]) begin
        p1_fall_pos <= pos_feedback_i;
      end
      if (pin_rise[PIN_PROBE2]) begin
        p2_rise_pos <= pos_feedback_i;
      end
    end
  end

  // probe capture flags; a write to probe control clears them, a new edge wins
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      probe_stat <= 16'h0000;
    end else if (ce_i) begin
      if (apb_wr && reg_idx == IDX_PROBE_CTRL) begin
        probe_stat <= 16'h0000;
      end
      if (pin_rise[PIN_PROBE1]) begin
        probe_stat[PSTAT_P1_RISE_BIT] <= 1'b1;
      end
      if (pin_fall[PIN_PROBE1]) begin
        probe_stat[PSTAT_P1_FALL_BIT] <= 1'b1;
      end
      if (pin_rise[PIN_PROBE2]) begin
        probe_stat[PSTAT_P2_RISE_BIT] <= 1'b1;
      end
    end
  end

  // selector decode and source selection for the active run
  assign sel_info = method_info(method_sel);
  assign run_src = run_info[MI_SRC_LO +: 3];
  assign special_case = (ENC_BITS == ENC_BITS_SPECIAL) && (qs_option == QS_OPT_SPECIAL)
                        && (gear_ratio == GEAR_SPECIAL);

  // level of the chosen deceleration source
  always_comb begin
    src_level = 1'b0;
    src_rise = 1'b0;
    src_fall = 1'b0;
    case (run_src)
      SRC_NEG_LIM: begin
        src_level = pin_sync[PIN_NEG_LIM];
        src_rise = pin_rise[PIN_NEG_LIM];
        src_fall = pin_fall[PIN_NEG_LIM];
      end
      SRC_POS_LIM: begin
        src_level = pin_sync[PIN_POS_LIM];
        src_rise = pin_rise[PIN_POS_LIM];
        src_fall = pin_fall[PIN_POS_LIM];
      end
      SRC_HOME: begin
        src_level = pin_sync[PIN_HOME];
        src_rise = pin_rise[PIN_HOME];
        src_fall = pin_fall[PIN_HOME];
      end
      SRC_NEG_STOP: src_level = neg_end_stop_i;
      SRC_POS_STOP: src_level = pos_end_stop_i;
      default: src_level = 1'b0;
    endcase
  end

  // a plain same-side rising method is satisfied at the decel point itself
  assign want_edge = run_info[MI_FALL] | run_info[MI_FAR];

  // homing sequencer
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
      run_info <= 8'h00;
      timeout_cnt <= 32'h00000000;
      done_flag <= 1'b0;
      timeout_flag <= 1'b0;
      undef_flag <= 1'b0;
      qstop_flag <= 1'b0;
      move_en_o <= 1'b0;
      move_fwd_o <= 1'b0;
      speed_o <= 32'h00000000;
      accel_o <= 32'h00000000;
      decel_o <= 32'h00000000;
      pos_load_o <= 1'b0;
      pos_load_val_o <= 32'h00000000;
    end else if (ce_i) begin
      pos_load_o <= 1'b0;
      if (state != ST_IDLE) begin
        timeout_cnt <= timeout_cnt + 32'h00000001;
      end
      if (qstop_req && state != ST_IDLE) begin
        // abort; special case stops with the steepest ramp
        state <= ST_IDLE;
        move_en_o <= 1'b0;
        speed_o <= 32'h00000000;
        qstop_flag <= 1'b1;
        decel_o <= special_case ? QS_DECEL_FORCED : accel_o;
      end else if (state != ST_IDLE && state != ST_DONE
                   && timeout_cnt >= TIMEOUT_CYCLES - 32'h00000001) begin
        state <= ST_IDLE;
        move_en_o <= 1'b0;
        speed_o <= 32'h00000000;
        timeout_flag <= 1'b1;
      end else begin
        case (state)
          ST_IDLE: begin
            if (start_req) begin
              done_flag <= 1'b0;
              timeout_flag <= 1'b0;
              qstop_flag <= 1'b0;
              timeout_cnt <= 32'h00000000;
              if (!sel_info[MI_VALID]) begin
                undef_flag <= 1'b1;
              end else begin
                undef_flag <= 1'b0;
                run_info <= sel_info;
                move_fwd_o <= sel_info[MI_FWD];
                // zero acceleration is never used as is
                if (homing_accel == 32'h00000000 || special_case) begin
                  accel_o <= (homing_accel == 32'h00000000) ? ACCEL_FORCED : homing_accel;
                  decel_o <= (homing_accel == 32'h00000000) ? ACCEL_FORCED : homing_accel;
                end else begin
                  accel_o <= homing_accel;
                  decel_o <= homing_accel;
                end
                if (sel_info[MI_SRC_LO +: 3] != SRC_NONE) begin
                  state <= ST_SEEK;
                  move_en_o <= 1'b1;
                  speed_o <= sw_speed;
                end else if (sel_info[MI_INDEX]) begin
                  state <= ST_INDEX;
                  move_en_o <= 1'b1;
                  speed_o <= zero_speed;
                end else begin
                  state <= ST_DONE;
                end
              end
            end
          end
          ST_SEEK: begin
            // fast search until the decel point is met
            if (src_level) begin
              speed_o <= zero_speed;
              if (want_edge) begin
                state <= ST_EDGE;
                // same-side falling backs off; far side carries on
                move_fwd_o <= run_info[MI_FAR] ? run_info[MI_FWD] : ~run_info[MI_FWD];
              end else if (run_info[MI_INDEX]) begin
                state <= ST_INDEX;
              end else begin
                state <= ST_DONE;
                move_en_o <= 1'b0;
              end
            end
          end
          ST_EDGE: begin
            // only the programmed edge arms the index search
            if ((run_info[MI_FALL] && src_fall) || (!run_info[MI_FALL] && src_rise)) begin
              if (run_info[MI_INDEX]) begin
                state <= ST_INDEX;
              end else begin
                state <= ST_DONE;
                move_en_o <= 1'b0;
              end
            end else if (run_info[MI_FAR] && !run_info[MI_FALL] && src_fall) begin
              // far side passed going out; turn back so it rises
              move_fwd_o <= ~move_fwd_o;
            end
          end
          ST_INDEX: begin
            // first index after arming is home
            if (pin_rise[PIN_INDEX]) begin
              state <= ST_DONE;
              move_en_o <= 1'b0;
            end
          end
          ST_DONE: begin
            // stop and rebase position
            state <= ST_IDLE;
            move_en_o <= 1'b0;
            speed_o <= 32'h00000000;
            done_flag <= 1'b1;
            pos_load_o <= 1'b1;
            pos_load_val_o <= home_offset;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // status pins mirror sequencer flops
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      homing_busy_o <= 1'b0;
      homing_done_o <= 1'b0;
      homing_timeout_error_o <= 1'b0;
    end else if (ce_i) begin
      homing_busy_o <= (state != ST_IDLE);
      homing_done_o <= done_flag;
      homing_timeout_error_o <= timeout_flag;
    end
  end

endmodule : hpl_homing_probe

// >>> hpl_homing_probe_end.sv
`timescale 1ns/1ps

// >>> hpl_homing_probe_monitor.sv
`timescale 1ns/1ps
module hpl_homing_probe_monitor #(
  parameter logic [31:0] TIMEOUT_CYCLES = 32'h000000C8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // homing
  input wire logic move_en_o,
  input wire logic [31:0] accel_o,
  input wire logic pos_load_o,
  input wire logic homing_busy_o,
  input wire logic homing_done_o,
  input wire logic homing_timeout_error_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // run length in busy cycles; a stuck run must end by the limit
  logic [31:0] busy_cnt;
  always_ff @(posedge sys_clk_i) begin
    busy_cnt <= (srst_i || !homing_busy_o) ? 32'h0 : busy_cnt + 32'h1;
  end
  // one wait state, then a one-cycle answer
  sequence s_answer; !pready_o ##1 pready_o ##1 !pready_o; endsequence
  property p_answer; psel_i && !penable_i |=> s_answer; endproperty
  property p_err; pslverr_o |-> pready_o; endproperty
  property p_rst; $fell(srst_i) |-> !move_en_o && !pos_load_o && !homing_busy_o; endproperty
  property p_load; pos_load_o |=> !pos_load_o; endproperty
  property p_done; $rose(homing_done_o) |-> $past(pos_load_o); endproperty
  property p_tmo; busy_cnt <= TIMEOUT_CYCLES + 32'h2; endproperty
  property p_tmo_flag; $rose(homing_timeout_error_o) |-> !homing_done_o; endproperty
  property p_accel; move_en_o |-> accel_o != 32'h0; endproperty
  a_answer: assert property (p_answer) else $error("apb answer timing wrong");
  a_err: assert property (p_err) else $error("error without ready");
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  a_load: assert property (p_load) else $error("position load not a pulse");
  a_done: assert property (p_done) else $error("done without position load");
  a_tmo: assert property (p_tmo) else $error("run outlived its limit");
  a_tmo_flag: assert property (p_tmo_flag) else $error("timeout with done");
  a_accel: assert property (p_accel) else $error("zero acceleration in motion");
endmodule : hpl_homing_probe_monitor
bind hpl_homing_probe hpl_homing_probe_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_mon (
  .sys_clk_i, .srst_i, .psel_i, .penable_i, .pready_o, .pslverr_o, .move_en_o, .accel_o,
  .pos_load_o, .homing_busy_o, .homing_done_o, .homing_timeout_error_o);

// >>> hpl_homing_probe_tb.sv
`timescale 1ns/1ps
module hpl_homing_probe_tb;
  import hpl_pkg::*;
  // stimulus
  logic sys_clk_i = 0, srst_i = 1, psel = 0, penable = 0, pwrite = 0;
  logic p1 = 0, p2 = 0, idx_on = 0, er, idx;
  logic [4:0] sw = 5'h00;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, pfb = 32'h0, rd, v, ofs, seed = 32'h653FADC5;
  logic [7:0] dly = 8'h05;
  // design outputs
  logic [31:0] prdata, speed, accel, dcl, ldv, ld_val, sp_seen, ac_seen;
  logic pready, perr, mv, fwd, ld, busy, done, tmo, mv_seen, fwd_seen;
  int n_mismatch = 0, check_count = 0;
  // register table and selectors
  logic [13:0] ri [9] = '{IDX_METHOD, IDX_ACCEL, IDX_PROBE_CTRL, IDX_PROBE_STAT, IDX_P1_RISE,
    IDX_P1_FALL, IDX_P2_RISE, IDX_SW_SPEED, IDX_ZERO_SPEED};
  logic [31:0] rv [9] = '{32'h1, 32'h53555555, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hD55555,
    32'h155555};
  logic [15:0] bad [4] = '{16'hF, 16'h10, 16'h1F, 16'h20};
  logic [15:0] good [4] = '{16'h23, 16'h22, 16'h21, 16'hFFFD};
  initial forever #2 sys_clk_i = ~sys_clk_i;
  hpl_homing_probe #(.TIMEOUT_CYCLES(32'hC8)) u_dut (.sys_clk_i, .srst_i, .ce_i(1'b1),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .neg_limit_i(sw[0]),
    .pos_limit_i(sw[1]), .home_switch_i(sw[2]), .enc_index_i(idx), .probe1_i(p1),
    .probe2_i(p2), .neg_end_stop_i(sw[3]), .pos_end_stop_i(sw[4]), .pos_feedback_i(pfb),
    .move_en_o(mv), .move_fwd_o(fwd), .speed_o(speed), .accel_o(accel), .decel_o(dcl),
    .pos_load_o(ld), .pos_load_val_o(ldv), .homing_busy_o(busy), .homing_done_o(done),
    .homing_timeout_error_o(tmo));
  hpl_field_model u_field (.sys_clk_i, .move_en_i(mv), .idx_on_i(idx_on), .dly_i(dly),
    .enc_index_o(idx));
  // what the run did at the motion and load outputs
  always @(posedge sys_clk_i) begin
    if (mv === 1'b1) {mv_seen, fwd_seen, sp_seen, ac_seen} <= {1'b1, fwd, speed, accel};
    if (ld === 1'b1) ld_val <= ldv;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [13:0] i, input logic [31:0] d);
    @(posedge sys_clk_i);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, i, 2'b00, d};
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    {rd, er} = {prdata, perr};
    {psel, penable} <= 2'b00;
  endtask : apb
  // wait until the run ends or gives up, at most 404 cycles
  task automatic wt();
    repeat (4) @(posedge sys_clk_i);
    repeat (400) begin
      @(posedge sys_clk_i);
      if (done === 1'b1 || tmo === 1'b1) break;
    end
  endtask : wt
  task automatic home(input logic [15:0] m);
    apb(1, IDX_METHOD, {16'h0, m});
    mv_seen = 0;
    apb(1, IDX_CTRL, 32'h1);
    wt();
    apb(0, IDX_STATUS, 32'h0);
  endtask : home
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (30000) @(posedge sys_clk_i);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge sys_clk_i);
    srst_i <= 0;
    foreach (ri[k]) begin
      apb(0, ri[k], 32'h0);
      chk(rd, rv[k], "reset value");
    end
    apb(0, 14'h0100, 32'h0);
    chk(er, 1, "unmapped error");
    apb(1, IDX_P1_RISE, xs());
    apb(0, IDX_P1_RISE, 32'h0);
    chk(rd, 32'h0, "read-only latch");
    apb(1, IDX_METHOD, 32'h24);
    apb(0, IDX_METHOD, 32'h0);
    chk(rd, 32'h1, "selector 36 dropped");
    foreach (bad[k]) begin
      home(bad[k]);
      chk(rd[STAT_UNDEF_BIT], 1, "undefined flag");
      chk(mv_seen, 0, "no motion");
    end
    ofs = xs();
    v = xs();
    apb(1, IDX_HOME_OFFSET, ofs);
    apb(1, IDX_ZERO_SPEED, v);
    apb(1, IDX_ACCEL, 32'h0);
    idx_on = 1;
    foreach (good[k]) begin
      dly = 8'h03 + 8'(xs() % 60);
      home(good[k]);
      chk(done, 1, "done");
      chk(ld_val, ofs, "home offset");
      if (k == 0) chk(mv_seen, 0, "still");
      if (k == 1 || k == 2) chk(fwd_seen, k == 1, "direction");
      if (k == 1) chk(sp_seen, v, "zero speed");
      if (k == 1) chk(ac_seen, 32'h1, "forced accel");
    end
    idx_on = 0;
    apb(1, IDX_METHOD, 32'h1);
    apb(1, IDX_CTRL, 32'h1);
    apb(1, IDX_SW_SPEED, xs());
    wt();
    chk(tmo, 1, "timeout");
    apb(0, IDX_SW_SPEED, 32'h0);
    chk(rd, 32'hD55555, "speed held while busy");
    apb(1, IDX_QS_OPTION, 32'(QS_OPT_SPECIAL));
    apb(1, IDX_GEAR, GEAR_SPECIAL);
    apb(1, IDX_CTRL, 32'h1);
    apb(1, IDX_CTRL, 32'h2);
    chk(busy, 1, "busy");
    apb(0, IDX_STATUS, 32'h0);
    chk(rd[STAT_QSTOP_BIT], 1, "qstop");
    chk(dcl, QS_DECEL_FORCED, "qstop decel");
    sw <= 5'(xs());
    for (int k = 0; k < 3; k++) begin
      v = xs();
      pfb <= v;
      if (k == 0) p1 <= 1;
      if (k == 1) p1 <= 0;
      if (k == 2) p2 <= 1;
      repeat (8) @(posedge sys_clk_i);
      apb(0, ri[4 + k], 32'h0);
      chk(rd, v, "probe latch");
    end
    apb(0, IDX_PROBE_STAT, 32'h0);
    chk(rd, 32'h7, "probe flags");
    tally_and_finish();
  end
endmodule : hpl_homing_probe_tb

// >>> hpl_pkg.sv
package hpl_pkg;

  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_METHOD = 14'h35B2;
  localparam logic [13:0] IDX_ACCEL = 14'h35B6;
  localparam logic [13:0] IDX_PROBE_CTRL = 14'h35F2;
  localparam logic [13:0] IDX_PROBE_STAT = 14'h35F4;
  localparam logic [13:0] IDX_P1_RISE = 14'h35F6;
  localparam logic [13:0] IDX_P1_FALL = 14'h35F8;
  localparam logic [13:0] IDX_P2_RISE = 14'h35FA;
  localparam logic [13:0] IDX_SW_SPEED = 14'h371C;
  localparam logic [13:0] IDX_ZERO_SPEED = 14'h381C;
  localparam logic [13:0] IDX_HOME_OFFSET = 14'h357A;
  localparam logic [13:0] IDX_CTRL = 14'h3F00;
  localparam logic [13:0] IDX_STATUS = 14'h3F01;
  localparam logic [13:0] IDX_QS_OPTION = 14'h3F02;
  localparam logic [13:0] IDX_GEAR = 14'h3F03;

  // reset values
  localparam logic [15:0] RST_METHOD = 16'h0001;
  localparam logic [31:0] RST_ACCEL = 32'h53555555;
  localparam logic [31:0] RST_SW_SPEED = 32'h00D55555;
  localparam logic [31:0] RST_ZERO_SPEED = 32'h00155555;
  localparam logic [15:0] RST_PROBE_CTRL = 16'h0000;
  localparam logic [31:0] RST_HOME_OFFSET = 32'h00000000;
  localparam logic [15:0] RST_QS_OPTION = 16'h0002;
  localparam logic [31:0] RST_GEAR = 32'h00000001;

  // accepted selector range
  localparam logic signed [15:0] METHOD_MIN = -16'sd3;
  localparam logic signed [15:0] METHOD_MAX = 16'sd35;

  // control and status bit positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_QSTOP_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_TIMEOUT_BIT = 2;
  localparam int STAT_UNDEF_BIT = 3;
  localparam int STAT_QSTOP_BIT = 4;

  // probe status flag positions
  localparam int PSTAT_P1_RISE_BIT = 0;
  localparam int PSTAT_P1_FALL_BIT = 1;
  localparam int PSTAT_P2_RISE_BIT = 2;

  // pin positions in the synchroniser vector
  localparam int PIN_NEG_LIM = 0;
  localparam int PIN_POS_LIM = 1;
  localparam int PIN_HOME = 2;
  localparam int PIN_INDEX = 3;
  localparam int PIN_PROBE1 = 4;
  localparam int PIN_PROBE2 = 5;
  localparam int PIN_COUNT = 6;

  // deceleration point sources
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_NEG_LIM = 3'h1;
  localparam logic [2:0] SRC_POS_LIM = 3'h2;
  localparam logic [2:0] SRC_HOME = 3'h3;
  localparam logic [2:0] SRC_NEG_STOP = 3'h4;
  localparam logic [2:0] SRC_POS_STOP = 3'h5;

  // method descriptor fields {valid, fwd, src[2:0], fall, far, index}
  localparam int MI_INDEX = 0;
  localparam int MI_FAR = 1;
  localparam int MI_FALL = 2;
  localparam int MI_SRC_LO = 3;
  localparam int MI_FWD = 6;
  localparam int MI_VALID = 7;

  // special case match values; forced rates for zero accel and special quick stop
  localparam logic [31:0] GEAR_SPECIAL = 32'h00800000;
  localparam logic [15:0] QS_OPT_SPECIAL = 16'h0001;
  localparam int ENC_BITS_SPECIAL = 23;
  localparam logic [31:0] ACCEL_FORCED = 32'h00000001;
  localparam logic [31:0] QS_DECEL_FORCED = 32'hFFFFFFFF;

  // timing
  localparam longint CLK_FREQ_KHZ = 250000;
  localparam longint HOMING_TIMEOUT_MS = 2500;
  localparam logic [31:0] HOMING_TIMEOUT_CYCLES = 32'(HOMING_TIMEOUT_MS * CLK_FREQ_KHZ);

  // sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SEEK = 5'b00010,
    ST_EDGE = 5'b00100,
    ST_INDEX = 5'b01000,
    ST_DONE = 5'b10000
  } hpl_state_t;

endpackage : hpl_pkg
